/* File: verilog/pmicg_pkg.sv */
// Package for the power-management pin-function block: register
// offsets, field positions, reset values, pin modes and pin functions.
// Assumes a plain 8-bit register port driven by an on-chip serial core.
`default_nettype none
package pmicg_pkg;

   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_PINS = 4;
   localparam int NUM_SRC = 8;

   // Register offsets
   localparam logic [7:0] ADDR_STATUS   = 8'h00; // Sticky event flags
   localparam logic [7:0] ADDR_MASK     = 8'h01; // One masks a source
   localparam logic [7:0] ADDR_LEVEL    = 8'h02; // Real-time levels
   localparam logic [7:0] ADDR_CFG0     = 8'h03; // Pin 1..4 at 03..06
   localparam logic [7:0] ADDR_OUTDATA  = 8'h07; // Plain output data
   localparam logic [7:0] ADDR_PININ    = 8'h08; // Synced pin levels
   localparam logic [7:0] ADDR_LEDCODE1 = 8'h09; // First sink code
   localparam logic [7:0] ADDR_LEDCODE2 = 8'h0a; // Second sink code
   localparam logic [7:0] ADDR_OKSEL    = 8'h0b; // Regulator per pin

   // Pin configuration fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_FUNC_LSB = 3;
   localparam int SRC_PB       = 7;  // Push-button source bit

   // LED code fields and current figures in mA
   localparam int LED_HI_LSB = 3;
   localparam logic [4:0] LED_BASE_MA = 5'h08;
   localparam logic [4:0] LED_MAX_MA  = 5'h16;

   // Reset values
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_CFG  = 8'h00;
   localparam logic [7:0] RST_LED  = 8'h00;
   localparam logic [3:0] RST_OUTDATA = 4'h0;  // All plain outputs low
   localparam logic [7:0] RST_OKSEL   = 8'h00; // Every pin on regulator 0

   // Pin drive modes
   typedef enum logic [2:0] {
      MODE_IN, MODE_PP, MODE_OD, MODE_LED, MODE_ANALOG
   } pmicg_mode_e;

   // Pin functions
   typedef enum logic [3:0] {
      FN_GPIO, FN_RESET, FN_PWRGOOD, FN_IRQ, FN_REGOK, FN_SEQIN,
      FN_SLEEP, FN_DSLEEP, FN_EXTSEQIN, FN_EXTSEQOUT, FN_VSCALE
   } pmicg_func_e;

endpackage : pmicg_pkg

`default_nettype wire

/* File: verilog/pmicg_pins.sv */
// Pin-function logic: four general pins, two LED sinks, interrupt pin,
// push-button input and serial pins in outline.
// Assumes system signals arrive on clk; pins are asynchronous to it.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Any status change pulls interrupt low
// - Mask bit stops that source asserting interrupt
// - Interrupt held until host reads status
// - Fault still present keeps interrupt asserted
// - Interrupt pin only pulls low
// - Pins: input, push-pull, open-drain, LED, analog
// - Pins route the listed system functions
// - Pin 1: no LED, input/open-drain/push-pull
// - Pin 2 same options as pin 1
// - Pin 3: LED one, input or open-drain
// - Pin 4 like pin 3, drives LED two
// - LED mode sinks current from six-bit code
// - Upper zero: low value; one: 8+2*low
// - Serial pins open-drain standard target
// - Push-button input feeds system functions
// - Masking never hides real-time fault level
module pmicg_pins
   import pmicg_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Register port
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [DATA_W-1:0] regRdata,
   // Internal status sources and system signals
   input  wire logic [6:0]        faultIn,
   input  wire logic              systemResetOutN,
   input  wire logic              powerGoodOut,
   input  wire logic [3:0]        regulatorPowerOk,
   input  wire logic              extSeqOut,
   // Functions taken from pins
   output logic                   seqInput,
   output logic                   sleepCtl,
   output logic                   deepSleepMode,
   output logic                   extSeqIn,
   output logic                   dynamicVoltageScaling,
   // General pins
   input  wire logic [3:0]        generalPinIn,
   output logic      [3:0]        generalPinOut,
   output logic      [3:0]        generalPinOe,
   output logic      [3:0]        analogEn,
   // LED sinks, current in mA
   output logic                   firstLedSinkEn,
   output logic                   secondLedSinkEn,
   output logic      [4:0]        firstLedSinkMa,
   output logic      [4:0]        secondLedSinkMa,
   // Interrupt pin, open drain
   output logic                   interruptRequestNOut,
   output logic                   interruptRequestNOe,
   // Push-button pin
   input  wire logic              pushbuttonInputN,
   output logic                   pushbuttonPressed,
   // Serial pins
   input  wire logic              sclIn,
   input  wire logic              sdaIn,
   input  wire logic              sclHoldLow,
   input  wire logic              sdaPullLow,
   output logic                   sclSync,
   output logic                   sdaSync,
   output logic                   sclOut,
   output logic                   sclOe,
   output logic                   sdaOut,
   output logic                   sdaOe
);

   // LED code to current in mA
   function automatic logic [4:0] ledMa(input logic [5:0] code);
      logic [4:0] low;
      low = {2'b00, code[2:0]};
      if (code[5:LED_HI_LSB] == 3'h0) begin
         ledMa = low;
      end else if (code[5:LED_HI_LSB] == 3'h1) begin
         ledMa = LED_BASE_MA + {low[3:0], 1'b0};
      end else begin
         ledMa = LED_MAX_MA;
      end
   endfunction : ledMa

   // Pin synchronisers: first and second stages
   logic [6:0]          syncA_r;     // First stage, read by syncB only
   logic [6:0]          syncB_r;     // Second stage
   // Register state
   logic [NUM_SRC-1:0]  status_r;    // Sticky event flags
   logic [NUM_SRC-1:0]  status_nxt;  // Next flags
   logic [NUM_SRC-1:0]  mask_r;      // Source masks
   logic [NUM_SRC-1:0]  levelPrev_r; // Previous source levels
   logic [7:0]          cfg_r [NUM_PINS]; // Pin configuration
   logic [3:0]          outData_r;   // Plain output data
   logic [5:0]          ledCode1_r;  // First sink code
   logic [5:0]          ledCode2_r;  // Second sink code
   logic [7:0]          okSel_r;     // Regulator select, 2 bits a pin
   logic [DATA_W-1:0]   rdata_r;     // Read data
   logic [3:0]          pinOut_r;    // Registered pin data
   logic [3:0]          pinOe_r;     // Registered pin enables
   logic                irqOe_r;     // Registered interrupt drive

   // Decoded pin state
   logic [3:0]          pinSync;     // Synced pin levels
   logic [3:0]          pinIsIn;     // Pin acts as digital input
   logic [3:0]          pinIsLed;    // Pin in LED mode
   logic [3:0]          pinOutVal;   // Function value per pin
   logic [3:0]          pinOeNxt;    // Next enable per pin
   logic [3:0]          pinOutNxt;   // Next data per pin
   logic [3:0]          hitSeq;      // Per-pin input function hits
   logic [3:0]          hitSleep;
   logic [3:0]          hitDeep;
   logic [3:0]          hitExt;
   logic [3:0]          hitScale;

   // Bus and interrupt decode
   logic [NUM_SRC-1:0]  levelVec;    // Real-time source levels
   logic [NUM_SRC-1:0]  evtVec;      // Level changes
   logic [NUM_SRC-1:0]  clrVec;      // Flags the host clears
   logic                statusRd;    // Status read strobe
   logic                statusWr;    // Status write strobe
   logic                irqAny;      // Unmasked flag pending
   logic [DATA_W-1:0]   rdNxt;       // Read mux result

   // Two-flop synchronisers for every asynchronous pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncA_r <= 7'h7f;
         syncB_r <= 7'h7f;
      end else begin
         syncA_r <= {sdaIn, sclIn, pushbuttonInputN, generalPinIn};
         syncB_r <= syncA_r;
      end
   end

   assign pinSync           = syncB_r[3:0];
   assign pushbuttonPressed = ~syncB_r[4];
   assign sclSync           = syncB_r[5];
   assign sdaSync           = syncB_r[6];

   // Serial pins only pull low, pull-ups are external
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe  = sclHoldLow;
   assign sdaOe  = sdaPullLow;

   // Source levels and their changes
   assign levelVec = {pushbuttonPressed, faultIn};
   assign evtVec   = levelVec ^ levelPrev_r;

   // Host clears by read or write-one, but not while level remains
   assign statusRd = regRd && (regAddr == ADDR_STATUS);
   assign statusWr = regWr && (regAddr == ADDR_STATUS);
   assign clrVec   = ({NUM_SRC{statusRd}} |
                      (statusWr ? regWdata : 8'h00)) & ~levelVec;
   // New event wins over a clear in the same cycle
   assign status_nxt = evtVec | (status_r & ~clrVec);
   assign irqAny     = |(status_r & ~mask_r);

   // Open drain interrupt: never driven high
   assign interruptRequestNOut = 1'b0;
   assign interruptRequestNOe  = irqOe_r;

   // Flags, interrupt drive and previous levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_r    <= '0;
         levelPrev_r <= '0;
         irqOe_r     <= 1'b0;
      end else begin
         status_r    <= status_nxt;
         levelPrev_r <= levelVec;
         irqOe_r     <= |(status_nxt & ~mask_r);
      end
   end

   // Software-written control registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_r     <= RST_MASK;
         outData_r  <= RST_OUTDATA;
         ledCode1_r <= RST_LED[5:0];
         ledCode2_r <= RST_LED[5:0];
         okSel_r    <= RST_OKSEL;
      end else if (regWr) begin
         case (regAddr)
            ADDR_MASK:     mask_r     <= regWdata;
            ADDR_OUTDATA:  outData_r  <= regWdata[3:0];
            ADDR_LEDCODE1: ledCode1_r <= regWdata[5:0];
            ADDR_LEDCODE2: ledCode2_r <= regWdata[5:0];
            ADDR_OKSEL:    okSel_r    <= regWdata;
            default:       ;                                // Others
         endcase
      end
   end

   // Per-pin configuration, function routing and drive
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : gPin
         pmicg_mode_e modeRaw;   // Mode as written
         pmicg_func_e func;      // Function as written
         logic        legal;     // Mode allowed on this pin
         logic [1:0]  sel;       // Regulator chosen for this pin

         assign modeRaw = pmicg_mode_e'(cfg_r[gi][CFG_FUNC_LSB-1:0]);
         assign func    = pmicg_func_e'(cfg_r[gi][CFG_FUNC_LSB+3:CFG_FUNC_LSB]);
         assign sel     = okSel_r[2*gi+1 -: 2];
         // Pins 1,2 offer push-pull, pins 3,4 offer the LED sink
         assign legal = (modeRaw == MODE_IN) || (modeRaw == MODE_OD) ||
                        (modeRaw == MODE_ANALOG) ||
                        (modeRaw == MODE_PP  && gi < 2) ||
                        (modeRaw == MODE_LED && gi >= 2);
         // Illegal modes fall back to input
         assign pinIsIn[gi]  = !legal || modeRaw == MODE_IN;
         assign pinIsLed[gi] = legal && modeRaw == MODE_LED;
         assign analogEn[gi] = legal && modeRaw == MODE_ANALOG;

         // Output function selection
         assign pinOutVal[gi] =
            (func == FN_RESET)     ? systemResetOutN :
            (func == FN_PWRGOOD)   ? powerGoodOut :
            (func == FN_IRQ)       ? ~irqAny :
            (func == FN_REGOK)     ? regulatorPowerOk[sel] :
            (func == FN_EXTSEQOUT) ? extSeqOut :
                                     outData_r[gi];

         // Push-pull drives both levels, open drain pulls low only
         assign pinOeNxt[gi] = legal && ((modeRaw == MODE_PP) ||
                               (modeRaw == MODE_OD && !pinOutVal[gi]));
         assign pinOutNxt[gi] = (legal && modeRaw == MODE_PP) ?
                                pinOutVal[gi] : 1'b0;

         // Input function hits
         assign hitSeq[gi]   = pinIsIn[gi] && func == FN_SEQIN &&
                               pinSync[gi];
         assign hitSleep[gi] = pinIsIn[gi] && func == FN_SLEEP &&
                               pinSync[gi];
         assign hitDeep[gi]  = pinIsIn[gi] && func == FN_DSLEEP &&
                               pinSync[gi];
         assign hitExt[gi]   = pinIsIn[gi] && func == FN_EXTSEQIN &&
                               pinSync[gi];
         assign hitScale[gi] = pinIsIn[gi] && func == FN_VSCALE &&
                               pinSync[gi];

         // Configuration register and pin drive flops
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cfg_r[gi]    <= RST_CFG;
               pinOut_r[gi] <= 1'b0;
               pinOe_r[gi]  <= 1'b0;
            end else begin
               if (regWr && regAddr == ADDR_CFG0 + 8'(gi)) begin
                  cfg_r[gi] <= regWdata;
               end
               pinOut_r[gi] <= pinOutNxt[gi];
               pinOe_r[gi]  <= pinOeNxt[gi];
            end
         end
      end
   endgenerate

   assign generalPinOut = pinOut_r;
   assign generalPinOe  = pinOe_r;

   // Input functions taken from any pin acting as input and set to them
   assign seqInput              = |hitSeq;
   assign sleepCtl              = |hitSleep;
   assign deepSleepMode         = |hitDeep;
   assign extSeqIn              = |hitExt;
   assign dynamicVoltageScaling = |hitScale;

   // LED sinks on pins 3 and 4
   assign firstLedSinkEn  = pinIsLed[2];
   assign secondLedSinkEn = pinIsLed[3];
   assign firstLedSinkMa  = ledMa(ledCode1_r);
   assign secondLedSinkMa = ledMa(ledCode2_r);

   // Read mux; unmapped offsets read zero
   assign rdNxt =
      (regAddr == ADDR_STATUS)       ? status_r :
      (regAddr == ADDR_MASK)         ? mask_r :
      (regAddr == ADDR_LEVEL)        ? levelVec :
      (regAddr == ADDR_CFG0)         ? cfg_r[0] :
      (regAddr == ADDR_CFG0 + 8'h01) ? cfg_r[1] :
      (regAddr == ADDR_CFG0 + 8'h02) ? cfg_r[2] :
      (regAddr == ADDR_CFG0 + 8'h03) ? cfg_r[3] :
      (regAddr == ADDR_OUTDATA)      ? {4'h0, outData_r} :
      (regAddr == ADDR_PININ)        ? {4'h0, pinSync} :
      (regAddr == ADDR_LEDCODE1)     ? {2'b00, ledCode1_r} :
      (regAddr == ADDR_LEDCODE2)     ? {2'b00, ledCode2_r} :
      (regAddr == ADDR_OKSEL)        ? okSel_r : 8'h00;

   // Read data stands one cycle after the strobe only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= regRd ? rdNxt : 8'h00;
      end
   end

   assign regRdata = rdata_r;

   // Checks
   sequence sStatusRead;
      regRd && regAddr == ADDR_STATUS && !regWr;
   endsequence

   sequence sFaultStays;
      |(levelVec & status_r & ~mask_r);
   endsequence

   AST_EVT_ASSERTS: assert property (@(posedge clk) disable iff (rst)
      |(evtVec & ~mask_r) |=> interruptRequestNOe)
      else $error("unmasked change did not pull interrupt low");

   AST_MASK_BLOCKS: assert property (@(posedge clk) disable iff (rst)
      (!(|(status_r & ~mask_r)) && $stable(mask_r)) |-> !interruptRequestNOe)
      else $error("masked flags drove interrupt");

   AST_HOLD_NO_READ: assert property (@(posedge clk) disable iff (rst)
      (|(status_r & ~mask_r) && !regWr && !regRd) |=> interruptRequestNOe)
      else $error("interrupt released without a status read");

   AST_FAULT_REMAINS: assert property (@(posedge clk) disable iff (rst)
      (sStatusRead and sFaultStays) |=> interruptRequestNOe)
      else $error("interrupt released while fault present");

   AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
      !interruptRequestNOut)
      else $error("interrupt pin driven high");

   AST_NO_PP_HI: assert property (@(posedge clk) disable iff (rst)
      (generalPinOe[3:2] & generalPinOut[3:2]) == 2'b00)
      else $error("pin 3 or 4 driven high");

   AST_SLEEP_ROUTE: assert property (@(posedge clk) disable iff (rst)
      (pinIsIn[0] && cfg_r[0][6:3] == 4'h6 && pinSync[0]) |-> sleepCtl)
      else $error("sleep input not routed");

   AST_LED_CODE: assert property (@(posedge clk) disable iff (rst)
      (regWr && regAddr == ADDR_LEDCODE1 && regWdata[5:3] == 3'h1) |=>
      firstLedSinkMa == LED_BASE_MA + {1'b0, $past(regWdata[2:0]), 1'b0})
      else $error("LED current code mapped wrongly");

   AST_LED_MAX: assert property (@(posedge clk) disable iff (rst)
      (ledCode2_r[5:4] != 2'b00) |-> secondLedSinkMa == LED_MAX_MA)
      else $error("undocumented LED code not at maximum");

   AST_LEVEL_READ: assert property (@(posedge clk) disable iff (rst)
      (regRd && regAddr == ADDR_LEVEL) |=> regRdata == $past(levelVec))
      else $error("level read does not show real-time faults");

   AST_PB_SYNC: assert property (@(posedge clk) disable iff (rst)
      ##2 pushbuttonPressed == !$past(pushbuttonInputN, 2))
      else $error("push-button level not passed through two flops");

endmodule : pmicg_pins

`default_nettype wire

/* File: verif/pmicg_host_model.sv */
// Far-side model: board pull-ups, external pin drivers and host clock hold.
// Assumes the bench supplies external pin drive and the host SCL hold.
`timescale 1ns/10ps
`default_nettype none
module pmicg_host_model (
   // Design drive of the general pins
   input  wire logic [3:0] pinOut,
   input  wire logic [3:0] pinOe,
   // External drivers on the general pins
   input  wire logic [3:0] extDrv,
   input  wire logic [3:0] extVal,
   output logic      [3:0] pinLevel,
   // Interrupt line
   input  wire logic       irqOut,
   input  wire logic       irqOe,
   output logic            irqWire,
   // Serial lines
   input  wire logic       sclOut,
   input  wire logic       sclOe,
   input  wire logic       sdaOut,
   input  wire logic       sdaOe,
   input  wire logic       hostSclLow,
   output logic            sclWire,
   output logic            sdaWire
);
   // Undriven pins float to the board pull-up
   assign pinLevel = (pinOe & pinOut) | (~pinOe & extDrv & extVal)
                   | (~pinOe & ~extDrv);
   // Interrupt line is only pulled low, the pull-up gives the high level
   assign irqWire = ~(irqOe & ~irqOut);
   // Serial lines pulled up; either party may hold SCL low, only the design holds SDA low
   assign sclWire = ~(sclOe & ~sclOut) & ~hostSclLow;
   assign sdaWire = ~(sdaOe & ~sdaOut);
endmodule : pmicg_host_model
`default_nettype wire

/* File: verif/pmicg_pins_bench.sv */
// Bench for the pin-function block: register tasks and directed tests.
// Assumes the host model resolves pins and the pulled-up lines.
`timescale 1ns/10ps
`default_nettype none
module pmicg_pins_bench
   import pmicg_pkg::*;
;
   // Design and model signals
   logic        clk = 1'b0;
   logic        rst;
   logic [7:0]  regAddr, regWdata, regRdata;
   logic        regWr, regRd, irqWire, hostSclLow;
   logic [6:0]  faultIn;
   logic        systemResetOutN, powerGoodOut, extSeqOut;
   logic [3:0]  regulatorPowerOk, generalPinIn, generalPinOut, generalPinOe;
   logic [3:0]  analogEn, extDrv, extVal;
   logic        seqInput, sleepCtl, deepSleepMode, extSeqIn;
   logic        dynamicVoltageScaling, firstLedSinkEn, secondLedSinkEn;
   logic [4:0]  firstLedSinkMa, secondLedSinkMa, fnVec;
   logic        interruptRequestNOut, interruptRequestNOe;
   logic        pushbuttonInputN, pushbuttonPressed;
   logic        sclIn, sdaIn, sclHoldLow, sdaPullLow, sclSync, sdaSync;
   logic        sclOut, sclOe, sdaOut, sdaOe;
   // Counters for the verdict
   int          miscompares = 0;
   int          n_checks = 0;
   // Function tables for the pin loops
   pmicg_func_e inFn [5] = '{FN_SEQIN, FN_SLEEP, FN_DSLEEP, FN_EXTSEQIN,
                             FN_VSCALE};
   pmicg_func_e outFn [5] = '{FN_RESET, FN_PWRGOOD, FN_IRQ, FN_REGOK,
                              FN_EXTSEQOUT};
   logic [4:0]  outExp [2] = '{5'b01100, 5'b10111};

   assign fnVec = {seqInput, sleepCtl, deepSleepMode, extSeqIn,
                   dynamicVoltageScaling};

   // Free-running 100 MHz clock
   always #5 clk = ~clk;

   // Design under test
   pmicg_pins u_pmicg_pins (
      .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .faultIn(faultIn),
      .systemResetOutN(systemResetOutN), .powerGoodOut(powerGoodOut),
      .regulatorPowerOk(regulatorPowerOk), .extSeqOut(extSeqOut),
      .seqInput(seqInput), .sleepCtl(sleepCtl),
      .deepSleepMode(deepSleepMode), .extSeqIn(extSeqIn),
      .dynamicVoltageScaling(dynamicVoltageScaling),
      .generalPinIn(generalPinIn), .generalPinOut(generalPinOut),
      .generalPinOe(generalPinOe), .analogEn(analogEn),
      .firstLedSinkEn(firstLedSinkEn), .secondLedSinkEn(secondLedSinkEn),
      .firstLedSinkMa(firstLedSinkMa), .secondLedSinkMa(secondLedSinkMa),
      .interruptRequestNOut(interruptRequestNOut),
      .interruptRequestNOe(interruptRequestNOe),
      .pushbuttonInputN(pushbuttonInputN),
      .pushbuttonPressed(pushbuttonPressed), .sclIn(sclIn), .sdaIn(sdaIn),
      .sclHoldLow(sclHoldLow), .sdaPullLow(sdaPullLow), .sclSync(sclSync),
      .sdaSync(sdaSync), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
      .sdaOe(sdaOe)
   );

   // Far side of the pins
   pmicg_host_model u_pmicg_host_model (
      .pinOut(generalPinOut), .pinOe(generalPinOe), .extDrv(extDrv),
      .extVal(extVal), .pinLevel(generalPinIn),
      .irqOut(interruptRequestNOut), .irqOe(interruptRequestNOe),
      .irqWire(irqWire), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .hostSclLow(hostSclLow), .sclWire(sclIn),
      .sdaWire(sdaIn)
   );

   // Expected sink current in mA for a six-bit code
   function automatic logic [4:0] ledMa(input logic [5:0] code);
      if (code[5:3] == 3'h0) return {2'h0, code[2:0]};
      if (code[5:3] == 3'h1) return LED_BASE_MA + {1'h0, code[2:0], 1'b0};
      return LED_MAX_MA;
   endfunction : ledMa

   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Wait a number of clock edges
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr    <= 1'b0;
   endtask : wr

   // One-cycle read, data taken in the following cycle
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask : rdc

   // Counts, verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // Watchdog against a hang
   initial begin
      cyc(20000);
      miscompares++;
      conclude();
   end

   // Main test sequence
   initial begin
      rst = 1'b1; regAddr = 8'h00; regWdata = 8'h00; regWr = 1'b0;
      regRd = 1'b0; faultIn = 7'h00; systemResetOutN = 1'b0;
      powerGoodOut = 1'b0; regulatorPowerOk = 4'h4; extSeqOut = 1'b0;
      extDrv = 4'hf; extVal = 4'ha; pushbuttonInputN = 1'b1;
      sclHoldLow = 1'b0; sdaPullLow = 1'b0; hostSclLow = 1'b0;
      cyc(16);
      rst <= 1'b0;
      // Reset values, refused accesses, synced pin levels
      rdc(ADDR_MASK, RST_MASK);
      rdc(ADDR_CFG0, RST_CFG);
      rdc(ADDR_LEDCODE1, RST_LED);
      wr(8'h40, 8'hff);
      rdc(8'h40, 8'h00);
      wr(ADDR_LEVEL, 8'hff);
      rdc(ADDR_LEVEL, 8'h00);
      rdc(ADDR_PININ, 8'h0a);
      $display("test registers done");
      // Input functions taken from pin 1
      for (int k = 0; k < 5; k++) begin
         wr(ADDR_CFG0, {1'b0, inFn[k], MODE_IN});
         @(posedge clk);
         extVal[0] <= 1'b1;
         cyc(4);
         chk({3'h0, fnVec}, 8'h10 >> k);
         @(posedge clk);
         extVal[0] <= 1'b0;
         cyc(4);
         chk({3'h0, fnVec}, 8'h00);
      end
      @(posedge clk);
      extDrv <= 4'h0;
      // Output functions on pin 2 in push-pull
      wr(ADDR_OKSEL, 8'h08);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         {systemResetOutN, powerGoodOut, extSeqOut} <= {3{p[0]}};
         regulatorPowerOk <= p[0] ? 4'hb : 4'h4;
         for (int k = 0; k < 5; k++) begin
            wr(ADDR_CFG0 + 8'h01, {1'b0, outFn[k], MODE_PP});
            cyc(3);
            chk({7'h0, generalPinIn[1]}, {7'h0, outExp[p][k]});
         end
      end
      $display("test functions done");
      // Drive modes per pin, refusals included
      wr(ADDR_OUTDATA, 8'h05);
      wr(ADDR_CFG0, {5'h0, MODE_PP});
      wr(ADDR_CFG0 + 8'h01, {5'h0, MODE_OD});
      wr(ADDR_CFG0 + 8'h02, {5'h0, MODE_PP});
      wr(ADDR_CFG0 + 8'h03, {5'h0, MODE_OD});
      cyc(3);
      chk({4'h0, generalPinOe}, 8'h0b);
      chk({4'h0, generalPinIn}, 8'h05);
      wr(ADDR_CFG0, {5'h0, MODE_LED});
      wr(ADDR_CFG0 + 8'h01, {5'h0, MODE_ANALOG});
      wr(ADDR_CFG0 + 8'h02, {5'h0, MODE_LED});
      wr(ADDR_CFG0 + 8'h03, {5'h0, MODE_LED});
      cyc(3);
      chk({6'h0, firstLedSinkEn, secondLedSinkEn}, 8'h03);
      chk({4'h0, analogEn}, 8'h02);
      chk({7'h0, generalPinOe[0]}, 8'h00);
      // Every sink current code on both sinks
      for (int c = 0; c < 64; c++) begin
         wr(ADDR_LEDCODE1, 8'(c));
         wr(ADDR_LEDCODE2, 8'(63 - c));
         cyc(1);
         chk({3'h0, firstLedSinkMa}, {3'h0, ledMa(6'(c))});
         chk({3'h0, secondLedSinkMa}, {3'h0, ledMa(6'(63 - c))});
      end
      $display("test pins done");
      // Interrupt raised, held while fault stays, released by read
      @(posedge clk);
      faultIn <= 7'h01;
      cyc(3);
      chk({7'h0, irqWire}, 8'h00);
      rdc(ADDR_STATUS, 8'h01);
      cyc(2);
      chk({7'h0, irqWire}, 8'h00);
      @(posedge clk);
      faultIn <= 7'h00;
      cyc(3);
      chk({7'h0, irqWire}, 8'h00);
      rdc(ADDR_STATUS, 8'h01);
      cyc(2);
      chk({7'h0, irqWire}, 8'h01);
      // Masked source: no interrupt, flags still live
      wr(ADDR_MASK, 8'h02);
      @(posedge clk);
      faultIn <= 7'h02;
      cyc(3);
      chk({7'h0, irqWire}, 8'h01);
      rdc(ADDR_LEVEL, 8'h02);
      rdc(ADDR_STATUS, 8'h02);
      @(posedge clk);
      faultIn <= 7'h00;
      cyc(2);
      wr(ADDR_STATUS, 8'hff);
      rdc(ADDR_STATUS, 8'h00);
      wr(ADDR_MASK, 8'h00);
      // Push-button press raises its own flag
      @(posedge clk);
      pushbuttonInputN <= 1'b0;
      cyc(4);
      chk({7'h0, pushbuttonPressed}, 8'h01);
      chk({7'h0, irqWire}, 8'h00);
      rdc(ADDR_LEVEL, 8'h80);
      @(posedge clk);
      pushbuttonInputN <= 1'b1;
      cyc(4);
      rdc(ADDR_STATUS, 8'h80);
      cyc(2);
      chk({7'h0, irqWire}, 8'h01);
      $display("test interrupt done");
      // Serial lines: open-drain pulls and synced levels
      @(posedge clk);
      sclHoldLow <= 1'b1;
      sdaPullLow <= 1'b1;
      cyc(2);
      chk({6'h0, sclIn, sdaIn}, 8'h00);
      @(posedge clk);
      sclHoldLow <= 1'b0;
      sdaPullLow <= 1'b0;
      hostSclLow <= 1'b1;
      cyc(4);
      chk({6'h0, sclSync, sdaSync}, 8'h01);
      $display("test serial done");
      conclude();
   end
endmodule : pmicg_pins_bench
`default_nettype wire
